// ### bench/tb.sv
// Self-checking bench joining both ends of the transfer port
`timescale 1ns/1ps
`default_nettype none
`include "udtp_params.svh"
module tb;
    typedef struct {logic s; logic [31:0] v; logic [31:0] m;} udtp_tb_note_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] p_addr = 4'h0, u_addr = 4'h0;
    logic [31:0] p_wdata = 32'h0, u_wdata = 32'h0, p_rdata, u_rdata;
    logic p_wr = 1'b0, p_rd = 1'b0, u_wr = 1'b0, u_rd = 1'b0, irq;
    logic p_rd_q = 1'b0, u_rd_q = 1'b0, busy_d = 1'b0;
    logic [31:0] seed = 32'h0000_0FC6;
    logic [31:0] d;
    int bad_count = 0, checks = 0, busy_n = 0;
    udtp_tb_note_t exp_q[$];
    udtp_tb_note_t n;
    udtp_if bus();
    udtp_port #(.XFER_CYCLES(8)) udtp_port_i (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
        .i_addr(p_addr), .i_wdata(p_wdata), .i_wr(p_wr), .i_rd(p_rd), .o_rdata(p_rdata),
        .o_irq(irq), .bus(bus));
    udtp_user udtp_user_i (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_addr(u_addr),
        .i_wdata(u_wdata), .i_wr(u_wr), .i_rd(u_rd), .o_rdata(u_rdata), .bus(bus));
    udtp_sva udtp_sva_i (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .ready(bus.ready),
        .busy(bus.busy), .end_cycle(bus.end_cycle), .user_go(bus.user_go), .read(bus.read),
        .write(bus.write), .init(bus.init), .output_data_lines(bus.output_data_lines),
        .parity_out_low(bus.parity_out_low), .parity_out_high(bus.parity_out_high),
        .user_function_lines(bus.user_function_lines));
    // ------------------------------------------------------------
    // Clock, helpers and bus tasks
    // ------------------------------------------------------------
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic s, input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        if (s) begin
            u_addr <= a; u_wdata <= v; u_wr <= 1'b1;
        end else begin
            p_addr <= a; p_wdata <= v; p_wr <= 1'b1;
        end
        @(posedge ref_clk);
        p_wr <= 1'b0; u_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic s, input logic [3:0] a, input logic [31:0] v,
        input logic [31:0] m);
        @(posedge ref_clk);
        exp_q.push_back('{s, v & m, m});
        if (s) begin
            u_addr <= a; u_rd <= 1'b1;
        end else begin
            p_addr <= a; p_rd <= 1'b1;
        end
        @(posedge ref_clk);
        p_rd <= 1'b0; u_rd <= 1'b0;
    endtask : rd
    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wait_ready();
        int i;
        for (i = 0; i < 600 && bus.ready !== 1'b1; i++) @(posedge ref_clk);
        if (i == 600) begin
            bad_count++;
            end_sim();
        end
        idle(2);
    endtask : wait_ready
    task automatic end_sim();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Read data monitor and busy counter
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (p_rd_q || u_rd_q) begin
            n = exp_q.pop_front();
            check((n.s ? u_rdata : p_rdata) & n.m, n.v);
        end
        p_rd_q <= p_rd;
        u_rd_q <= u_rd;
        busy_d <= bus.busy;
        if (bus.busy === 1'b1 && busy_d === 1'b0) busy_n++;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        idle(2);
        rd(1'b0, `UDTP_ADDR_ISR, 32'h80, 32'h80);
        check(bus.output_data_lines, 32'h0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(1'b0, `UDTP_ADDR_FUNC, {16'h0, seed[15:8], 8'h0});
            wr(1'b1, `UDTP_ADDR_USTAT, {24'h0, seed[7:0]});
            idle(4);
            rd(1'b0, `UDTP_ADDR_FUNC, seed, 32'hFFFF);
            check(bus.user_function_lines, seed[15:8]);
        end
        wr(1'b1, `UDTP_ADDR_USTAT, 32'h0000_0200);
        idle(4);
        check(irq, 32'h1);
        rd(1'b0, `UDTP_ADDR_ISR, 32'h4000, 32'hC000);
        wr(1'b1, `UDTP_ADDR_USTAT, 32'h0);
        wr(1'b0, `UDTP_ADDR_ISR, 32'h4000);
        idle(2);
        check(irq, 32'h0);
        seed = lfsr(seed);
        d = seed;
        wr(1'b1, `UDTP_ADDR_UCMD, 32'h0001_0002);
        idle(12);
        check(busy_n, 32'h0);
        wr(1'b0, `UDTP_ADDR_OBUF, d);
        wr(1'b0, `UDTP_ADDR_CMD, 32'hFFFE_0001);
        idle(2);
        check({bus.ready, bus.write, bus.user_go}, 32'h3);
        wait_ready();
        check(busy_n, 32'h2);
        check(bus.output_data_lines, d[17:0]);
        rd(1'b1, `UDTP_ADDR_UDATA, d, 32'h3FFFF);
        seed = lfsr(seed);
        wr(1'b1, `UDTP_ADDR_UDATA, seed);
        wr(1'b1, `UDTP_ADDR_UCMD, 32'h0001_0001);
        wr(1'b0, `UDTP_ADDR_CMD, 32'hFFFF_0003);
        idle(2);
        check({bus.read, bus.write}, 32'h2);
        wait_ready();
        check(busy_n, 32'h3);
        rd(1'b0, `UDTP_ADDR_IBUF, seed, 32'h3FFFF);
        rd(1'b0, `UDTP_ADDR_ISR, 32'h0, 32'h2000);
        wr(1'b1, `UDTP_ADDR_USTAT, 32'h0000_0100);
        idle(4);
        rd(1'b0, `UDTP_ADDR_ISR, 32'hC480, 32'hC480);
        wr(1'b1, `UDTP_ADDR_USTAT, 32'h0);
        wr(1'b0, `UDTP_ADDR_FUNC, 32'h0000_A500);
        wr(1'b0, `UDTP_ADDR_CMD, 32'h0000_0004);
        idle(4);
        check({bus.user_function_lines, 6'h0, bus.output_data_lines}, 32'h0);
        rd(1'b0, `UDTP_ADDR_ISR, 32'h80, 32'h80);
        idle(4);
        check(busy_n, 32'h3);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ### bench/udtp_sva.sv
// Protocol checker for the user device transfer port interface
`timescale 1ns/1ps
`default_nettype none
module udtp_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic ready,
    input wire logic busy,
    input wire logic end_cycle,
    input wire logic user_go,
    input wire logic read,
    input wire logic write,
    input wire logic init,
    input wire logic [17:0] output_data_lines,
    input wire logic parity_out_low,
    input wire logic parity_out_high,
    input wire logic [7:0] user_function_lines
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Handshake, pulse, output parity and init checks
    // ------------------------------------------------------------
    a_go_drops_ready: assert property ($rose(user_go) |-> !ready)
        else $error("go pulse while ready high");
    a_go_dir_shown: assert property (user_go |-> (read ^ write))
        else $error("direction not shown during go");
    a_go_width: assert property ($rose(user_go) |-> ##19 user_go ##1 !user_go)
        else $error("go pulse width wrong");
    a_busy_in_run: assert property ($rose(busy) |-> $past(!ready))
        else $error("cycle started outside run mode");
    a_busy_length: assert property ($rose(busy) |-> busy[*8] ##1 !busy)
        else $error("busy length wrong");
    a_end_clears_busy: assert property ($rose(end_cycle) |-> !busy && $past(busy))
        else $error("busy not cleared with end pulse");
    a_end_width: assert property ($rose(end_cycle) |-> ##1 end_cycle ##1 !end_cycle)
        else $error("end pulse width wrong");
    a_parity_out: assert property ((parity_out_low == ~^output_data_lines[7:0]) &&
        (parity_out_high == ~^output_data_lines[15:8]))
        else $error("output parity not odd");
    a_init_clears: assert property ($fell(init) |->
        output_data_lines == 18'h0 && user_function_lines == 8'h0 && ready)
        else $error("init left outputs set");
    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_read_cycle: cover property ($rose(busy) && read);
    c_write_cycle: cover property ($rose(busy) && write);
    c_back_to_back: cover property ($fell(busy) ##[1:4] $rose(busy));
endmodule : udtp_sva
`default_nettype wire

// ### hw/udtp_port.sv
// Channel side of the user device transfer port
// Functional notes
// - Accepted command drops ready, pulses go
// - User drives input data on reads
// - User without parity holds inhibit high
// - Request falling edge sets cycle flip-flop
// - Status lines appear in function register
// - User error sets attention and error
// - Attention lines raise interrupt, no error
// - Odd parity checked unless inhibited
// - Output lines show buffer, cleared by init
// - Init output on clear command or reset
// - Function lines from register bits 8-15
// - Ready follows ready flag bit 7
// - Busy high while cycle runs
// - End of cycle pulse 100 ns
// - Go pulse about 1 us from go
// - Output parity odd per byte
// - Request during cycle held pending
// - Request before command retained
// - Input data captured as busy rises
// - Busy clears as end pulse asserts
// - New write word shown as busy clears
// - User takes write word within 250 ns
`timescale 1ns/1ps
`default_nettype none
`include "udtp_params.svh"
module udtp_port
    import udtp_pkg::*;
#(
    parameter int XFER_CYCLES = `UDTP_XFER_CYCLES,
    parameter int WC_WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    udtp_if.port_end bus
);
    localparam int GO_CYC = `UDTP_GO_CYCLES;
    localparam int END_CYC = `UDTP_END_CYCLES;
    initial begin
        if (XFER_CYCLES < 2 || XFER_CYCLES > 255 || WC_WIDTH < 1 || WC_WIDTH > 16) begin
            $error("udtp_port: unsupported parameter");
        end
    end
    function automatic logic odd_par(input logic [8:0] v);
        odd_par = ~^v;
    endfunction : odd_par
    typedef struct packed {
        udtp_cyc_t st;
        logic req_prev;
        logic pending;
        logic run;
        logic rd_dir;
        logic wr_dir;
        logic ready;
        logic err;
        logic attention_active_flag;
        logic perr;
        logic [7:0] func;
        logic [17:0] obuf;
        logic [17:0] obuf_next;
        logic [17:0] ibuf;
        logic [WC_WIDTH-1:0] wc;
        logic [7:0] go_cnt;
        logic [7:0] cyc_cnt;
        logic init;
        logic [3:0] att_prev;
        logic [31:0] rdata;
    } udtp_port_state_t;
    udtp_port_state_t q, d;
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic req_now;
        logic clr;
        logic start;
        logic [31:0] isr;
        req_now = 1'b0;
        clr = 1'b0;
        start = 1'b0;
        isr = 32'h0;
        d = q;
        d.rdata = 32'h0;
        d.init = 1'b0;
        req_now = bus.cycle_req_a | bus.cycle_req_b;
        d.req_prev = req_now;
        if (q.req_prev && !req_now) begin
            d.pending = 1'b1;
        end
        if (q.go_cnt != 8'h0) begin
            d.go_cnt = q.go_cnt - 8'h1;
        end
        // Software clear of attention first, so a same-cycle event wins
        if (i_wr && i_addr == `UDTP_ADDR_ISR && i_wdata[`UDTP_ISR_ATA]) begin
            d.attention_active_flag = 1'b0;
        end
        if (bus.user_error) begin
            d.err = 1'b1;
            d.attention_active_flag = 1'b1;
            d.ready = 1'b1;
            d.run = 1'b0;
        end
        if ((bus.attention_lines & ~q.att_prev) != 4'h0) begin
            d.attention_active_flag = 1'b1;
        end
        d.att_prev = bus.attention_lines;
        case (q.st)
            UDTP_IDLE: begin
                start = d.pending && q.run && !q.ready;
                if (start) begin
                    d.pending = 1'b0;
                    d.st = UDTP_BUSY;
                    d.cyc_cnt = 8'(XFER_CYCLES);
                    if (q.rd_dir) begin
                        d.ibuf = bus.input_data_lines;
                        if (!bus.input_parity_inhibit_line &&
                            (odd_par({bus.input_data_lines[7:0], bus.parity_in_low}) ||
                             odd_par({bus.input_data_lines[15:8], bus.parity_in_high}))) begin
                            d.perr = 1'b1;
                            d.err = 1'b1;
                            d.attention_active_flag = 1'b1;
                        end
                    end
                end
            end
            UDTP_BUSY: begin
                d.cyc_cnt = q.cyc_cnt - 8'h1;
                if (q.cyc_cnt == 8'(XFER_CYCLES / 2) && q.wr_dir) begin
                    d.obuf_next = q.obuf_next;
                end
                if (q.cyc_cnt == 8'h1) begin
                    d.st = UDTP_END;
                    d.cyc_cnt = 8'(END_CYC);
                    if (q.wr_dir) begin
                        d.obuf = q.obuf_next;
                    end
                    d.wc = q.wc + WC_WIDTH'(1);
                    if (q.wc == {WC_WIDTH{1'b1}}) begin
                        d.ready = 1'b1;
                        d.run = 1'b0;
                    end
                end
            end
            UDTP_END: begin
                d.cyc_cnt = q.cyc_cnt - 8'h1;
                if (q.cyc_cnt == 8'h1) begin
                    d.st = UDTP_IDLE;
                end
            end
            default: begin
                d.st = UDTP_IDLE;
            end
        endcase
        if (i_wr) begin
            case (i_addr)
                `UDTP_ADDR_CMD: begin
                    if (i_wdata[`UDTP_CMD_CLEAR]) begin
                        clr = 1'b1;
                    end else if (i_wdata[`UDTP_CMD_GO]) begin
                        d.run = 1'b1;
                        d.ready = 1'b0;
                        d.go_cnt = 8'(GO_CYC);
                        d.rd_dir = i_wdata[`UDTP_CMD_READ];
                        d.wr_dir = !i_wdata[`UDTP_CMD_READ];
                        d.wc = i_wdata[`UDTP_CMD_WC_LSB +: WC_WIDTH];
                        d.err = 1'b0;
                        d.perr = 1'b0;
                    end
                end
                `UDTP_ADDR_FUNC: begin
                    d.func = i_wdata[15:8];
                end
                `UDTP_ADDR_ISR: begin
                end
                `UDTP_ADDR_OBUF: begin
                    d.obuf_next = i_wdata[17:0];
                end
                default: begin
                end
            endcase
        end
        isr[`UDTP_ISR_ERR] = q.err;
        isr[`UDTP_ISR_ATA] = q.attention_active_flag;
        isr[`UDTP_ISR_PERR] = q.perr;
        isr[`UDTP_ISR_USER_ERR] = bus.user_error;
        isr[`UDTP_ISR_READY] = q.ready;
        if (i_rd) begin
            case (i_addr)
                `UDTP_ADDR_CMD: d.rdata = {q.wc, 14'h0, q.rd_dir, q.run};
                `UDTP_ADDR_FUNC: d.rdata = {16'h0, q.func, bus.device_status_lines};
                `UDTP_ADDR_ISR: d.rdata = isr;
                `UDTP_ADDR_OBUF: d.rdata = {14'h0, q.obuf};
                `UDTP_ADDR_IBUF: d.rdata = {14'h0, q.ibuf};
                default: d.rdata = 32'h0;
            endcase
        end
        if (clr) begin
            d.init = 1'b1;
            d.st = UDTP_IDLE;
            d.pending = 1'b0;
            d.run = 1'b0;
            d.ready = 1'b1;
            d.func = 8'h0;
            d.obuf = 18'h0;
            d.go_cnt = 8'h0;
            d.err = 1'b0;
            d.attention_active_flag = 1'b0;
            d.perr = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.ready <= 1'b1;
            q.init <= 1'b1;
        end else begin
            q <= d;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = q.rdata;
    assign o_irq = q.attention_active_flag;
    assign bus.output_data_lines = q.obuf;
    assign bus.parity_out_low = odd_par({q.obuf[7:0], 1'b0});
    assign bus.parity_out_high = odd_par({q.obuf[15:8], 1'b0});
    assign bus.init = q.init;
    assign bus.user_function_lines = q.func;
    assign bus.ready = q.ready;
    assign bus.busy = (q.st == UDTP_BUSY);
    assign bus.end_cycle = (q.st == UDTP_END);
    assign bus.user_go = (q.go_cnt != 8'h0);
    assign bus.read = q.rd_dir;
    assign bus.write = q.wr_dir;
endmodule : udtp_port
`default_nettype wire

// ### hw/udtp_user.sv
// User device end of the transfer port
`timescale 1ns/1ps
`default_nettype none
`include "udtp_params.svh"
module udtp_user
    import udtp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    udtp_if.user_end bus
);
    function automatic logic odd_par(input logic [7:0] v);
        odd_par = ~^v;
    endfunction : odd_par
    typedef struct packed {
        udtp_usr_t st;
        logic req;
        logic par_en;
        logic [17:0] data;
        logic [17:0] got;
        logic [7:0] status;
        logic err;
        logic [3:0] att;
        logic [15:0] count;
        logic [31:0] rdata;
    } udtp_user_state_t;
    udtp_user_state_t q, d;
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = 32'h0;
        case (q.st)
            UDTP_U_IDLE: begin
                if (q.count != 16'h0) begin
                    d.req = 1'b1;
                    d.st = UDTP_U_REQ;
                end
            end
            UDTP_U_REQ: begin
                d.req = 1'b0;
                d.st = UDTP_U_WAIT;
            end
            UDTP_U_WAIT: begin
                if (bus.end_cycle) begin
                    d.got = bus.output_data_lines;
                    d.count = q.count - 16'h1;
                    d.data = q.data + 18'h1;
                    d.st = UDTP_U_IDLE;
                end
            end
            default: begin
                d.st = UDTP_U_IDLE;
            end
        endcase
        if (bus.init) begin
            d.st = UDTP_U_IDLE;
            d.req = 1'b0;
            d.count = 16'h0;
        end
        if (i_wr) begin
            case (i_addr)
                `UDTP_ADDR_UCMD: begin
                    d.count = i_wdata[15:0];
                    d.par_en = i_wdata[16];
                end
                `UDTP_ADDR_UDATA: d.data = i_wdata[17:0];
                `UDTP_ADDR_USTAT: begin
                    d.status = i_wdata[7:0];
                    d.err = i_wdata[8];
                    d.att = i_wdata[12:9];
                end
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `UDTP_ADDR_UCMD: d.rdata = {14'h0, bus.busy, bus.ready, q.count};
                `UDTP_ADDR_UDATA: d.rdata = {14'h0, q.got};
                `UDTP_ADDR_UIN: d.rdata = {bus.user_function_lines, bus.init,
                    bus.read, bus.write, bus.user_go, bus.parity_out_high,
                    bus.parity_out_low, bus.output_data_lines};
                default: d.rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = q.rdata;
    assign bus.input_data_lines = q.data;
    assign bus.parity_in_low = odd_par(q.data[7:0]);
    assign bus.parity_in_high = odd_par(q.data[15:8]);
    assign bus.input_parity_inhibit_line = !q.par_en;
    assign bus.cycle_req_a = q.req;
    assign bus.cycle_req_b = 1'b0;
    assign bus.device_status_lines = q.status;
    assign bus.user_error = q.err;
    assign bus.attention_lines = q.att;
endmodule : udtp_user
`default_nettype wire

// ### shared/udtp_if.sv
// Signal bundle between the port and the user device
`timescale 1ns/1ps
`default_nettype none
interface udtp_if;
    logic [17:0] input_data_lines;
    logic parity_in_low;
    logic parity_in_high;
    logic input_parity_inhibit_line;
    logic cycle_req_a;
    logic cycle_req_b;
    logic [7:0] device_status_lines;
    logic user_error;
    logic [3:0] attention_lines;
    logic [17:0] output_data_lines;
    logic parity_out_low;
    logic parity_out_high;
    logic init;
    logic [7:0] user_function_lines;
    logic ready;
    logic busy;
    logic end_cycle;
    logic user_go;
    logic read;
    logic write;
    modport port_end (
        input input_data_lines, parity_in_low, parity_in_high, input_parity_inhibit_line,
        input cycle_req_a, cycle_req_b, device_status_lines, user_error, attention_lines,
        output output_data_lines, parity_out_low, parity_out_high, init,
        output user_function_lines, ready, busy, end_cycle, user_go, read, write
    );
    modport user_end (
        output input_data_lines, parity_in_low, parity_in_high, input_parity_inhibit_line,
        output cycle_req_a, cycle_req_b, device_status_lines, user_error, attention_lines,
        input output_data_lines, parity_out_low, parity_out_high, init,
        input user_function_lines, ready, busy, end_cycle, user_go, read, write
    );
endinterface : udtp_if
`default_nettype wire

// ### shared/udtp_params.svh
// Timing, address and field constants for the user device transfer port
`ifndef UDTP_PARAMS_SVH
`define UDTP_PARAMS_SVH
`define UDTP_CLK_PERIOD_NS 50
`define UDTP_GO_PULSE_NS 1000
`define UDTP_END_PULSE_NS 100
`define UDTP_GO_CYCLES ((`UDTP_GO_PULSE_NS + `UDTP_CLK_PERIOD_NS - 1) / `UDTP_CLK_PERIOD_NS)
`define UDTP_END_CYCLES ((`UDTP_END_PULSE_NS + `UDTP_CLK_PERIOD_NS - 1) / `UDTP_CLK_PERIOD_NS)
`define UDTP_XFER_CYCLES 8
`define UDTP_ADDR_CMD 4'h0
`define UDTP_ADDR_FUNC 4'h1
`define UDTP_ADDR_ISR 4'h2
`define UDTP_ADDR_OBUF 4'h3
`define UDTP_ADDR_IBUF 4'h4
`define UDTP_ADDR_UCMD 4'h8
`define UDTP_ADDR_UDATA 4'h9
`define UDTP_ADDR_USTAT 4'hA
`define UDTP_ADDR_UIN 4'hB
`define UDTP_CMD_GO 0
`define UDTP_CMD_READ 1
`define UDTP_CMD_CLEAR 2
`define UDTP_CMD_WC_LSB 16
`define UDTP_ISR_ERR 15
`define UDTP_ISR_ATA 14
`define UDTP_ISR_PERR 13
`define UDTP_ISR_USER_ERR 10
`define UDTP_ISR_READY 7
`endif

// ### shared/udtp_pkg.sv
// Types shared by both ends of the user device transfer port
package udtp_pkg;
    typedef enum logic [2:0] {
        UDTP_IDLE = 3'h0,
        UDTP_BUSY = 3'h1,
        UDTP_END = 3'h3
    } udtp_cyc_t;
    typedef enum logic [1:0] {
        UDTP_U_IDLE = 2'h0,
        UDTP_U_REQ = 2'h1,
        UDTP_U_WAIT = 2'h3
    } udtp_usr_t;
endpackage : udtp_pkg
